// *** rtl/isg_cfg.svh ***
// register map, field positions and reset values of the interrupt status block
`ifndef ISG_CFG_SVH
`define ISG_CFG_SVH
`define ISG_ADDR_IRQ_MODE   8'h28
`define ISG_ADDR_EVT_MASK   8'h29
`define ISG_ADDR_EVT_SUM    8'h2A
`define ISG_ADDR_CLIP_STAT  8'h2B
`define ISG_ADDR_PIN_DIR    8'h2C
`define ISG_ADDR_PIN_POL    8'h2D
`define ISG_ADDR_PIN_TRIG   8'h2E
`define ISG_ADDR_PIN_STAT   8'h2F
`define ISG_ADDR_PIN_MASK   8'h30
`define ISG_BIT_UNLOCK      7
`define ISG_BIT_LOCK        6
`define ISG_BIT_RAMP_UP     5
`define ISG_BIT_RAMP_DOWN   4
`define ISG_BIT_MUTE        3
`define ISG_BIT_CLIP        2
`define ISG_BIT_PIN         1
`define ISG_BIT_STYLE_HI    7
`define ISG_BIT_STYLE_LO    6
`define ISG_BIT_CLIP_TRIG   0
`define ISG_EVT_MASK_BITS   8'hFC
`define ISG_RST_BYTE        8'h00
`define ISG_RST_POL         7'h7F
`endif

// *** rtl/isg_pkg.sv ***
// types shared by the interrupt status and pin logic
package isg_pkg;
    typedef logic [7:0] isg_byte_t;
    // interrupt pin signalling, in field order 00, 01, 10, 11
    typedef enum logic [1:0] {
        ISG_IRQ_HIGH,
        ISG_IRQ_LOW,
        ISG_IRQ_OD_LOW,
        ISG_IRQ_RSVD
    } isg_irq_style_t;
endpackage

// *** rtl/isg_pin_cell.sv ***
// one general purpose pin: input capture, status bit and output driver
`timescale 1ns/1ps
`default_nettype none
module isg_pin_cell (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // pin
    input  wire logic pin_in,
    output var  logic pin_out_q,
    output var  logic pin_oe_q,
    // configuration
    input  wire logic dir,
    input  wire logic pol,
    input  wire logic trig,
    // status access
    input  wire logic wr_en,
    input  wire logic wr_val,
    input  wire logic rd_clr,
    output var  logic stat_q,
    output var  logic stat_d
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    wire  act_now  = pol ? s2_q : ~s2_q;
    wire  act_prev = pol ? s3_q : ~s3_q;
    // edge into the active level; both taps use the current polarity, so a polarity change alone fakes no edge
    wire  rise     = act_now & ~act_prev;

    // two stage synchroniser, third stage only for edge finding
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // next status value
    always_comb begin
        if (dir) begin
            stat_d = wr_en ? wr_val : stat_q;
        end else if (trig) begin
            // edge sticky, read clears, set wins
            stat_d = rise | (stat_q & ~rd_clr);
        end else begin
            stat_d = act_now;
        end
    end

    // status and driver flops; open drain only ever pulls low
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stat_q    <= 1'b0;
            pin_out_q <= 1'b0;
            pin_oe_q  <= 1'b0;
        end else begin
            stat_q    <= stat_d;
            pin_out_q <= dir & ~pol & stat_d;
            pin_oe_q  <= dir & (pol ? ~stat_d : 1'b1);
        end
    end
endmodule
`default_nettype wire

// *** rtl/isg_top.sv ***
// interrupt status collection, interrupt pin and general purpose pin control
`timescale 1ns/1ps
`default_nettype none
`include "isg_cfg.svh"
module isg_top
    import isg_pkg::*;
#(
    parameter int NUM_PINS = 7,
    parameter int NUM_CH   = 6,
    parameter int NUM_PMSK = 4
) (
    // clock and reset
    input  wire logic                REF_CLK,
    input  wire logic                RST_B,
    // control port register access
    input  wire logic [7:0]          REG_ADDR,
    input  wire logic                REG_WR,
    input  wire logic                REG_RD,
    input  wire logic [7:0]          REG_WDATA,
    output var  logic [7:0]          REG_RDATA,
    output var  logic                REG_RVALID,
    // events from converter, volume and mute sequencers
    input  wire logic                UNLOCK_DET,
    input  wire logic                LOCK_DET,
    input  wire logic                RAMP_UP_DONE,
    input  wire logic                RAMP_DOWN_DONE,
    input  wire logic                MUTE_DONE,
    // per channel clipping from the output stage
    input  wire logic [NUM_CH-1:0]   CLIP_DET,
    // general purpose pins
    input  wire logic [NUM_PINS-1:0] GPIO_IN,
    output var  logic [NUM_PINS-1:0] GPIO_OUT,
    output var  logic [NUM_PINS-1:0] GPIO_OE,
    // interrupt pin
    output var  logic                IRQ_OUT,
    output var  logic                IRQ_OE
);
    // configuration registers
    isg_irq_style_t      style_q;
    logic                clip_trig_q;
    isg_byte_t           emask_q;
    logic [NUM_PINS-1:0] dir_q;
    logic [NUM_PINS-1:0] pol_q;
    logic [NUM_PINS-1:0] trig_q;
    logic [NUM_PMSK-1:0] pmask_q;
    // status registers
    logic                unlock_q;
    logic                unlock_d;
    logic                lock_q;
    logic                lock_d;
    logic                rup_q;
    logic                rup_d;
    logic                rdn_q;
    logic                rdn_d;
    logic                mute_q;
    logic                mute_d;
    logic                clip_sum_q;
    logic                clip_sum_d;
    logic                pin_sum_q;
    logic                pin_sum_d;
    logic [NUM_CH-1:0]   clip_q;
    logic [NUM_CH-1:0]   clip_d;
    logic [NUM_PINS-1:0] pin_stat_q;
    logic [NUM_PINS-1:0] pin_stat_d;
    logic [NUM_PINS-1:0] pin_out;
    logic [NUM_PINS-1:0] pin_oe;
    logic [NUM_PINS-1:0] pmask_full;
    logic                irq_out_d;
    logic                irq_oe_d;

    // address decode
    wire sel_mode = REG_ADDR == `ISG_ADDR_IRQ_MODE;
    wire sel_emsk = REG_ADDR == `ISG_ADDR_EVT_MASK;
    wire sel_sum  = REG_ADDR == `ISG_ADDR_EVT_SUM;
    wire sel_clip = REG_ADDR == `ISG_ADDR_CLIP_STAT;
    wire sel_dir  = REG_ADDR == `ISG_ADDR_PIN_DIR;
    wire sel_pol  = REG_ADDR == `ISG_ADDR_PIN_POL;
    wire sel_trig = REG_ADDR == `ISG_ADDR_PIN_TRIG;
    wire sel_stat = REG_ADDR == `ISG_ADDR_PIN_STAT;
    wire sel_pmsk = REG_ADDR == `ISG_ADDR_PIN_MASK;
    // strobes; a read has side effects only on the read cycle
    wire wr_mode  = REG_WR & sel_mode;
    wire wr_emsk  = REG_WR & sel_emsk;
    wire wr_dir   = REG_WR & sel_dir;
    wire wr_pol   = REG_WR & sel_pol;
    wire wr_trig  = REG_WR & sel_trig;
    wire wr_stat  = REG_WR & sel_stat;
    wire wr_pmsk  = REG_WR & sel_pmsk;
    wire rd_sum   = REG_RD & sel_sum;
    wire rd_clip  = REG_RD & sel_clip;
    wire rd_stat  = REG_RD & sel_stat;

    // configuration writes
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            style_q     <= ISG_IRQ_HIGH;
            clip_trig_q <= 1'b0;
            emask_q     <= `ISG_RST_BYTE;
            dir_q       <= '0;
            pol_q       <= `ISG_RST_POL;
            trig_q      <= '0;
            pmask_q     <= '0;
        end else begin
            if (wr_mode) begin
                style_q     <= isg_irq_style_t'(REG_WDATA[7:6]);
                clip_trig_q <= REG_WDATA[`ISG_BIT_CLIP_TRIG];
            end
            if (wr_emsk) begin
                emask_q <= REG_WDATA & `ISG_EVT_MASK_BITS;
            end
            if (wr_dir) begin
                dir_q <= REG_WDATA[NUM_PINS-1:0];
            end
            if (wr_pol) begin
                pol_q <= REG_WDATA[NUM_PINS-1:0];
            end
            if (wr_trig) begin
                trig_q <= REG_WDATA[NUM_PINS-1:0];
            end
            if (wr_pmsk) begin
                pmask_q <= REG_WDATA[NUM_PMSK-1:0];
            end
        end
    end

    // mask bits exist for the low pins only; upper pins never interrupt
    assign pmask_full = NUM_PINS'(pmask_q);

    // converter lock state: the newest report wins, unlock beats lock
    always_comb begin
        unlock_d = (UNLOCK_DET & emask_q[`ISG_BIT_UNLOCK])
                 | (unlock_q & ~rd_sum & ~LOCK_DET);
        lock_d   = (LOCK_DET & ~UNLOCK_DET & emask_q[`ISG_BIT_LOCK])
                 | (lock_q & ~rd_sum & ~UNLOCK_DET);
    end

    // edge events; a set in the read cycle survives the read
    // summary read clears
    assign rup_d  = (RAMP_UP_DONE & emask_q[`ISG_BIT_RAMP_UP])
                  | (rup_q & ~rd_sum);
    assign rdn_d  = (RAMP_DOWN_DONE & emask_q[`ISG_BIT_RAMP_DOWN])
                  | (rdn_q & ~rd_sum);
    assign mute_d = (MUTE_DONE & emask_q[`ISG_BIT_MUTE])
                  | (mute_q & ~rd_sum);

    // channel flags ignore the clip mask so software can poll them
    // no mask applied
    always_comb begin
        if (clip_trig_q) begin
            clip_d = CLIP_DET | (clip_q & ~{NUM_CH{rd_clip}});
        end else begin
            clip_d = CLIP_DET;
        end
    end

    // summaries use next values so a clearing read never leaves a stale set
    // clip summary from all flags
    assign clip_sum_d = (|clip_d & emask_q[`ISG_BIT_CLIP])
                      | (clip_sum_q & ~rd_clip);
    assign pin_sum_d  = |(pin_stat_d & pmask_full & ~dir_q)
                      | (pin_sum_q & ~rd_stat);

    // status flops
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            unlock_q   <= 1'b0;
            lock_q     <= 1'b0;
            rup_q      <= 1'b0;
            rdn_q      <= 1'b0;
            mute_q     <= 1'b0;
            clip_sum_q <= 1'b0;
            pin_sum_q  <= 1'b0;
            clip_q     <= '0;
        end else begin
            unlock_q   <= unlock_d;
            lock_q     <= lock_d;
            rup_q      <= rup_d;
            rdn_q      <= rdn_d;
            mute_q     <= mute_d;
            clip_sum_q <= clip_sum_d;
            pin_sum_q  <= pin_sum_d;
            clip_q     <= clip_d;
        end
    end

    // one cell per general purpose pin
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            isg_pin_cell u_cell (
                .clk       (REF_CLK),
                .rst_b     (RST_B),
                .pin_in    (GPIO_IN[gi]),
                .pin_out_q (pin_out[gi]),
                .pin_oe_q  (pin_oe[gi]),
                .dir       (dir_q[gi]),
                .pol       (pol_q[gi]),
                .trig      (trig_q[gi]),
                .wr_en     (wr_stat),
                .wr_val    (REG_WDATA[gi]),
                .rd_clr    (rd_stat),
                .stat_q    (pin_stat_q[gi]),
                .stat_d    (pin_stat_d[gi])
            );
        end
    endgenerate

    // summary view and interrupt request
    wire [7:0] sum_view = {unlock_q, lock_q, rup_q, rdn_q, mute_q,
                           clip_sum_q, pin_sum_q, 1'b0};
    // only unmasked events reach the pin; the pin summary skips the event mask and is gated by the pin mask instead
    wire irq_any = |(sum_view & emask_q) | pin_sum_q;

    // pin signalling style; reserved code keeps the pin idle
    always_comb begin
        case (style_q)
            ISG_IRQ_HIGH: begin
                irq_out_d = irq_any;
                irq_oe_d  = 1'b1;
            end
            ISG_IRQ_LOW: begin
                irq_out_d = ~irq_any;
                irq_oe_d  = 1'b1;
            end
            ISG_IRQ_OD_LOW: begin
                irq_out_d = 1'b0;
                irq_oe_d  = irq_any;
            end
            default: begin
                irq_out_d = 1'b0;
                irq_oe_d  = 1'b0;
            end
        endcase
    end

    // read data select; unmapped addresses read zero
    wire [7:0] rd_mux =
        sel_mode ? {style_q, 5'h00, clip_trig_q} :
        sel_emsk ? emask_q :
        sel_sum  ? sum_view :
        sel_clip ? 8'(clip_q) :
        sel_dir  ? 8'(dir_q) :
        sel_pol  ? 8'(pol_q) :
        sel_trig ? 8'(trig_q) :
        sel_stat ? 8'(pin_stat_q) :
        sel_pmsk ? 8'(pmask_q) : `ISG_RST_BYTE;

    // registered outputs; interrupt lags the summary by one cycle
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            REG_RDATA  <= `ISG_RST_BYTE;
            REG_RVALID <= 1'b0;
            IRQ_OUT    <= 1'b0;
            IRQ_OE     <= 1'b0;
            GPIO_OUT   <= '0;
            GPIO_OE    <= '0;
        end else begin
            REG_RDATA  <= REG_RD ? rd_mux : `ISG_RST_BYTE;
            REG_RVALID <= REG_RD;
            IRQ_OUT    <= irq_out_d;
            IRQ_OE     <= irq_oe_d;
            GPIO_OUT   <= pin_out;
            GPIO_OE    <= pin_oe;
        end
    end

    // checks on the status and pin logic
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    AST_UNLOCK_SET: assert property (
        (UNLOCK_DET && emask_q[7]) |=> unlock_q && !lock_q)
        else $error("unlock event not captured");
    AST_LOCK_DROPS_UNLOCK: assert property (
        (LOCK_DET && !UNLOCK_DET && unlock_q) |=> !unlock_q)
        else $error("pending unlock survived lock");
    AST_SUM_READ_CLR: assert property (
        (rd_sum && !UNLOCK_DET && !LOCK_DET && !RAMP_UP_DONE
         && !RAMP_DOWN_DONE && !MUTE_DONE) |=> sum_view[7:3] == 5'h00)
        else $error("summary read did not clear edge bits");
    AST_SUM_READ_KEEP: assert property (
        (rd_sum && !rd_clip && !rd_stat)
        |=> (clip_sum_q || !$past(clip_sum_q)) && (pin_sum_q || !$past(pin_sum_q)))
        else $error("summary read cleared clip or pin bit");
    AST_CLIP_OR: assert property (
        (|clip_q && $past(emask_q[2])) |-> clip_sum_q)
        else $error("clip summary misses a channel flag");
    AST_CLIP_EDGE_CLR: assert property (
        (rd_clip && clip_trig_q && CLIP_DET == '0) |=> clip_q == '0)
        else $error("edge clip flags not cleared by read");
    AST_CLIP_UNMASKED: assert property (
        (CLIP_DET[0] && !emask_q[2]) |=> clip_q[0])
        else $error("clip flag lost while masked");
    AST_POL_RESET: assert property (
        $past(!RST_B) |-> (pol_q == 7'h7F && dir_q == '0 && trig_q == '0))
        else $error("pin configuration reset value wrong");
    AST_OUT_CMOS: assert property (
        ($past(dir_q[0], 2) && !$past(pol_q[0], 2))
        |-> GPIO_OE[0] && GPIO_OUT[0] == $past(pin_stat_q[0]))
        else $error("push-pull output does not follow status");
    AST_IRQ_HIGH: assert property (
        (irq_any && style_q == ISG_IRQ_HIGH && !wr_mode) |=> IRQ_OUT && IRQ_OE)
        else $error("active high interrupt not raised");
    AST_IRQ_OD_IDLE: assert property (
        (!irq_any && style_q == ISG_IRQ_OD_LOW && !wr_mode) |=> !IRQ_OE && !IRQ_OUT)
        else $error("open drain interrupt driven while idle");

    COV_LOCK_AFTER_UNLOCK: cover property (unlock_q ##[1:50] lock_q);
    COV_CLIP_EDGE_READ: cover property (clip_trig_q && |clip_q && rd_clip);
    COV_PIN_IRQ: cover property (pin_sum_q && IRQ_OUT);
endmodule
`default_nettype wire

// *** tb/isg_pin_ext.sv ***
// external parts on the general purpose pins: pull-ups and bench drivers
`timescale 1ns/1ps
`default_nettype none
module isg_pin_ext (
    // pins as driven by the device
    input  wire logic [6:0] gpio_out,
    input  wire logic [6:0] gpio_oe,
    output var  logic [6:0] gpio_in,
    // external driver set by the bench
    input  wire logic [6:0] ext_val,
    input  wire logic [6:0] ext_en
);
    // device drive wins, then the bench driver; a line nobody drives rises on its pull-up, so open drain reads high
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            gpio_in[i] = gpio_oe[i] ? gpio_out[i] : (ext_en[i] ? ext_val[i] : 1'h1);
        end
    end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the interrupt status and pin block
`timescale 1ns/1ps
`default_nettype none
`include "isg_cfg.svh"
module testbench import isg_pkg::*;;
    logic       clk;
    logic       rst_b;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    isg_byte_t  rdata;
    logic       rvalid;
    logic [4:0] evt;
    logic [5:0] clip;
    logic [6:0] gin;
    logic [6:0] gout;
    logic [6:0] goe;
    logic [6:0] ext_val;
    logic [6:0] ext_en;
    logic       irq;
    logic       irq_oe;
    int         fail_count;
    int         n_compared;

    isg_top uut (
        .REF_CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
        .UNLOCK_DET(evt[4]), .LOCK_DET(evt[3]), .RAMP_UP_DONE(evt[2]),
        .RAMP_DOWN_DONE(evt[1]), .MUTE_DONE(evt[0]), .CLIP_DET(clip),
        .GPIO_IN(gin), .GPIO_OUT(gout), .GPIO_OE(goe), .IRQ_OUT(irq), .IRQ_OE(irq_oe)
    );

    isg_pin_ext ext (
        .gpio_out(gout), .gpio_oe(goe), .gpio_in(gin), .ext_val(ext_val), .ext_en(ext_en)
    );

    // 25 MHz reference clock
    always #20 clk = ~clk;

    task automatic chk(input isg_byte_t got, input isg_byte_t exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // inputs always move 1 ns after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // trailing idle cycle keeps strobes from being raised again in the same step
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'h1;
        cyc(1);
        wr = 1'h0;
        cyc(1);
    endtask

    // read data is registered, so it stands in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input isg_byte_t exp);
        addr = a;
        rd = 1'h1;
        cyc(1);
        rd = 1'h0;
        chk({7'h0, rvalid}, 8'h01);
        chk(rdata, exp);
        cyc(1);
    endtask

    task automatic pulse(input logic [4:0] e, input logic [5:0] c);
        evt = e;
        clip = c;
        cyc(1);
        evt = 5'h0;
        clip = 6'h0;
        cyc(2);
    endtask

    // external pins held low so level inputs settle inactive
    task automatic do_reset;
        rst_b = 1'h0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'h0;
        rd = 1'h0;
        evt = 5'h0;
        clip = 6'h0;
        ext_val = 7'h00;
        ext_en = 7'h7F;
        cyc(16);
        rst_b = 1'h1;
        cyc(1);
    endtask

    task automatic t_reset;
        do_reset;
        chk({6'h0, irq, irq_oe}, 8'h01);
        rd_chk(`ISG_ADDR_IRQ_MODE, 8'h00);
        rd_chk(`ISG_ADDR_EVT_MASK, 8'h00);
        rd_chk(`ISG_ADDR_EVT_SUM, 8'h00);
        rd_chk(`ISG_ADDR_CLIP_STAT, 8'h00);
        rd_chk(`ISG_ADDR_PIN_DIR, 8'h00);
        rd_chk(`ISG_ADDR_PIN_POL, 8'h7F);
        rd_chk(`ISG_ADDR_PIN_TRIG, 8'h00);
        rd_chk(`ISG_ADDR_PIN_STAT, 8'h00);
        rd_chk(`ISG_ADDR_PIN_MASK, 8'h00);
        wr_reg(8'h40, 8'hFF);
        rd_chk(8'h40, 8'h00);
        wr_reg(`ISG_ADDR_EVT_SUM, 8'hFF);
        rd_chk(`ISG_ADDR_EVT_SUM, 8'h00);
        wr_reg(`ISG_ADDR_EVT_MASK, 8'hFF);
        rd_chk(`ISG_ADDR_EVT_MASK, 8'hFC);
        $display("test reset values done");
    endtask

    task automatic t_events;
        do_reset;
        wr_reg(`ISG_ADDR_EVT_MASK, 8'hFC);
        pulse(5'h07, 6'h00);
        pulse(5'h10, 6'h00);
        chk({6'h0, irq, irq_oe}, 8'h03);
        rd_chk(`ISG_ADDR_EVT_SUM, 8'hB8);
        rd_chk(`ISG_ADDR_EVT_SUM, 8'h00);
        chk({6'h0, irq, irq_oe}, 8'h01);
        pulse(5'h10, 6'h00);
        pulse(5'h08, 6'h00);
        rd_chk(`ISG_ADDR_EVT_SUM, 8'h40);
        pulse(5'h18, 6'h00);
        rd_chk(`ISG_ADDR_EVT_SUM, 8'h80);
        wr_reg(`ISG_ADDR_EVT_MASK, 8'h00);
        pulse(5'h1F, 6'h00);
        rd_chk(`ISG_ADDR_EVT_SUM, 8'h00);
        chk({6'h0, irq, irq_oe}, 8'h01);
        $display("test edge events done");
    endtask

    task automatic t_clip_edge;
        do_reset;
        wr_reg(`ISG_ADDR_IRQ_MODE, 8'h01);
        pulse(5'h00, 6'h21);
        rd_chk(`ISG_ADDR_CLIP_STAT, 8'h21);
        rd_chk(`ISG_ADDR_CLIP_STAT, 8'h00);
        wr_reg(`ISG_ADDR_EVT_MASK, 8'h04);
        pulse(5'h00, 6'h12);
        rd_chk(`ISG_ADDR_EVT_SUM, 8'h04);
        rd_chk(`ISG_ADDR_EVT_SUM, 8'h04);
        rd_chk(`ISG_ADDR_CLIP_STAT, 8'h12);
        rd_chk(`ISG_ADDR_EVT_SUM, 8'h00);
        $display("test clip edge done");
    endtask

    task automatic t_clip_level;
        do_reset;
        wr_reg(`ISG_ADDR_EVT_MASK, 8'h04);
        clip = 6'h01;
        cyc(3);
        rd_chk(`ISG_ADDR_CLIP_STAT, 8'h01);
        rd_chk(`ISG_ADDR_CLIP_STAT, 8'h01);
        rd_chk(`ISG_ADDR_EVT_SUM, 8'h04);
        clip = 6'h00;
        cyc(3);
        rd_chk(`ISG_ADDR_EVT_SUM, 8'h04);
        rd_chk(`ISG_ADDR_CLIP_STAT, 8'h00);
        rd_chk(`ISG_ADDR_EVT_SUM, 8'h00);
        $display("test clip level done");
    endtask

    task automatic t_pin_edge;
        do_reset;
        wr_reg(`ISG_ADDR_PIN_TRIG, 8'h05);
        wr_reg(`ISG_ADDR_PIN_MASK, 8'h01);
        ext_val = 7'h05;
        cyc(5);
        rd_chk(`ISG_ADDR_EVT_SUM, 8'h02);
        rd_chk(`ISG_ADDR_EVT_SUM, 8'h02);
        chk({6'h0, irq, irq_oe}, 8'h03);
        rd_chk(`ISG_ADDR_PIN_STAT, 8'h05);
        rd_chk(`ISG_ADDR_PIN_STAT, 8'h00);
        rd_chk(`ISG_ADDR_EVT_SUM, 8'h00);
        $display("test pin edge done");
    endtask

    task automatic t_pin_level;
        do_reset;
        wr_reg(`ISG_ADDR_PIN_POL, 8'h7D);
        wr_reg(`ISG_ADDR_PIN_MASK, 8'h02);
        cyc(4);
        rd_chk(`ISG_ADDR_PIN_STAT, 8'h02);
        rd_chk(`ISG_ADDR_PIN_STAT, 8'h02);
        rd_chk(`ISG_ADDR_EVT_SUM, 8'h02);
        ext_val = 7'h02;
        cyc(4);
        rd_chk(`ISG_ADDR_PIN_STAT, 8'h00);
        rd_chk(`ISG_ADDR_EVT_SUM, 8'h00);
        $display("test pin level done");
    endtask

    task automatic t_outputs;
        do_reset;
        ext_en = 7'h7C;
        wr_reg(`ISG_ADDR_PIN_DIR, 8'h03);
        wr_reg(`ISG_ADDR_PIN_POL, 8'h7E);
        wr_reg(`ISG_ADDR_PIN_STAT, 8'h03);
        cyc(2);
        chk({1'h0, goe}, 8'h01);
        chk({1'h0, gin}, 8'h03);
        wr_reg(`ISG_ADDR_PIN_STAT, 8'h00);
        cyc(2);
        chk({1'h0, goe}, 8'h03);
        chk({1'h0, gout}, 8'h00);
        $display("test pin outputs done");
    endtask

    task automatic t_irq_style;
        isg_byte_t exp [4];
        exp = '{8'h03, 8'h01, 8'h01, 8'h00};
        do_reset;
        wr_reg(`ISG_ADDR_EVT_MASK, 8'h80);
        pulse(5'h10, 6'h00);
        for (int s = 0; s < 4; s++) begin
            wr_reg(`ISG_ADDR_IRQ_MODE, {s[1:0], 6'h00});
            cyc(1);
            chk({6'h0, irq, irq_oe}, exp[s]);
        end
        wr_reg(`ISG_ADDR_IRQ_MODE, 8'h40);
        rd_chk(`ISG_ADDR_EVT_SUM, 8'h80);
        chk({6'h0, irq, irq_oe}, 8'h03);
        wr_reg(`ISG_ADDR_IRQ_MODE, 8'h80);
        chk({6'h0, irq, irq_oe}, 8'h00);
        $display("test interrupt styles done");
    endtask

    initial begin
        clk = 1'h0;
        fail_count = 0;
        n_compared = 0;
        t_reset;
        t_events;
        t_clip_edge;
        t_clip_level;
        t_pin_edge;
        t_pin_level;
        t_outputs;
        t_irq_style;
        summarize;
    end
endmodule
`default_nettype wire
